// >>> include/csp_pkg.sv
package csp_pkg;
    // Clock rate and derived timing
    localparam int CLK_HZ = 25_000_000;
    localparam int NS_PER_S = 1_000_000_000;
    localparam int CLK_NS = NS_PER_S / CLK_HZ;
    // Pulse widths in microseconds, as used by the receiver
    localparam int FIRST_US = 160;
    localparam int OTHER_US = 80;
    localparam int FIRST_CYC = FIRST_US * 1000 / CLK_NS;
    localparam int OTHER_CYC = OTHER_US * 1000 / CLK_NS;
    // Edge lead ahead of ignition, degrees
    localparam int LEAD_DEG = 2;
    // Crank angle in tenths of a degree, 0..7199 over one cycle
    localparam int ANG_W = 13;
    localparam logic [ANG_W-1:0] CYCLE_TENTHS = 13'h1c20;
    localparam logic [ANG_W-1:0] LEAD_TENTHS = 13'h0014;
    // Six-cylinder default pattern, 120 degrees apart
    localparam int MAX_PULSES = 16;
    localparam int DEF_PULSES = 6;
    localparam logic [ANG_W-1:0] DEF_SPACING = 13'h04b0;
    localparam int WIDTH_W = 16;
    localparam int IDX_W = 4;
endpackage

// >>> tb/crank_angle_sync_pulse_output_tb_top.sv
`timescale 1ns/1ps
module crank_angle_sync_pulse_output_tb_top;
    import csp_pkg::*;
    localparam int FW = 8;
    localparam int OW = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tick = 1'b0;
    logic valid = 1'b0;
    logic shut = 1'b0;
    logic [ANG_W-1:0] ang = '0;
    logic [ANG_W-1:0] lead = '0;
    logic sync_o;
    int err_count = 0;
    int tests_run = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    csp_sync_out #(.FIRST_W(FW), .OTHER_W(OW)) dut (.clk(clk),
        .rst_n(rst_n), .crank_angle(ang), .crank_tick(tick),
        .crank_valid(valid), .ign_shutdown(shut),
        .ign_angle_base(13'h0000), .lead_time_tenths(lead),
        .crank_sync_pulse_output(sync_o));
    csp_rx_model #(.LONG_W(FW)) rx (.clk(clk), .rst_n(rst_n),
        .sync_line(sync_o), .crank_angle(ang));
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // Inputs change 1 ns after the edge, never on it
    task automatic step(input int a, input logic t);
        @(posedge clk);
        #1;
        ang = a[ANG_W-1:0];
        tick = t;
    endtask
    task automatic finish_test;
        $display("tests %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Two full cycles, one tick per clock, so lead equals OW tenths
    task automatic t_pattern;
        int k;
        rx.widths.delete();
        rx.cyls.delete();
        rx.angles.delete();
        for (int c = 0; c < 2 * 7200; c++) step(c % 7200, 1'b1);
        repeat (4) step(0, 1'b0);
        chk("idle level", 1, 16'(sync_o));
        chk("pulse count", 12, 16'(rx.widths.size()));
        for (int i = 0; i < 12; i++) begin
            k = (i + 1) % 6;
            // The receiver logs the angle one clock after the rise edge
            chk("rise angle", 16'((k == 0 ? int'(CYCLE_TENTHS)
                : k * int'(DEF_SPACING)) - int'(LEAD_TENTHS) + 1),
                16'(rx.angles[i]));
            chk("width", 16'(k == 0 ? FW : OW), 16'(rx.widths[i]));
            chk("cylinder", 16'(i < 5 ? 0 : k == 0 ? 1 : i - 4),
                16'(rx.cyls[i]));
        end
        $display("pattern test done");
    endtask
    // Matches are refused while unsynced or shut down; shutdown aborts
    task automatic t_abort;
        int n;
        n = rx.widths.size();
        valid = 1'b0;
        for (int a = 1170; a < 1186; a++) step(a, 1'b1);
        valid = 1'b1;
        shut = 1'b1;
        for (int a = 1170; a < 1186; a++) step(a, 1'b1);
        chk("blocked pulses", 16'(n), 16'(rx.widths.size()));
        shut = 1'b0;
        for (int a = 1176; a < 1179; a++) step(a, 1'b1);
        chk("pulse started", 0, 16'(sync_o));
        @(posedge clk);
        #1;
        shut = 1'b1;
        @(posedge clk);
        #1;
        chk("abort level", 1, 16'(sync_o));
        shut = 1'b0;
        $display("abort test done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        valid = 1'b1;
        lead = 13'(OW);
        chk("reset level", 1, 16'(sync_o));
        t_pattern();
        t_abort();
        finish_test();
    end
    // Watchdog well beyond the 14500 or so clocks the tests need
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule

// >>> tb/csp_rx_model.sv
`timescale 1ns/1ps
// Receiving controller: times each low period in clocks, takes the rise
// as active edge and numbers cylinders from the long pulse
module csp_rx_model #(
    parameter int LONG_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync_line,
    input wire logic [csp_pkg::ANG_W-1:0] crank_angle
);
    import csp_pkg::*;
    int low_cnt;
    int cyl;
    int widths[$];
    int cyls[$];
    int angles[$];
    // Low time is counted in clocks, so width resolution is one cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt = 0;
            cyl = 0;
        end else if (sync_line === 1'b0) begin
            low_cnt++;
        end else if (low_cnt != 0) begin
            // Until a long pulse is seen the cylinder stays unknown (0)
            if (low_cnt == LONG_W) cyl = 1;
            else if (cyl != 0) cyl = cyl % DEF_PULSES + 1;
            widths.push_back(low_cnt);
            cyls.push_back(cyl);
            angles.push_back(int'(crank_angle));
            low_cnt = 0;
        end
    end
endmodule

// >>> verilog/csp_angle_match.sv
`timescale 1ns/1ps
// One comparator per slot: raises hit when the crank angle equals the slot
// angle and the slot is enabled
module csp_angle_match #(
    parameter int N = csp_pkg::MAX_PULSES
) (
    input wire logic [csp_pkg::ANG_W-1:0] angle,
    input wire logic [N*csp_pkg::ANG_W-1:0] slot_angle,
    input wire logic [N-1:0] slot_en,
    output logic [N-1:0] hit
);
    import csp_pkg::*;
    genvar i;
    // Equality compare; angle steps by one tenth so no slot is skipped
    generate
        for (i = 0; i < N; i++) begin : g_slot
            assign hit[i] = slot_en[i] &&
                (slot_angle[i*ANG_W +: ANG_W] == angle);
        end
    endgenerate
endmodule

// >>> verilog/csp_sync_out.sv
`timescale 1ns/1ps
// How it works
// R1 - Output idles high; each pulse is a low period ending in a rise.
// R2 - Each rise sits at a set crank angle, own width; 16 slots, only the first 6 enabled.
// R3 - Six-cylinder default: rise two degrees before each ignition angle.
// R4 - Falling edge leads the rise by exactly the configured width.
// R5 - First cylinder gets 160 us low, others get 80 us low.
// R6 - Rise angles are chosen to land before top dead centre.
// R7 - Receiver takes the rise as active edge and measures low width.
// R8 - Receiver maps a 160 us pulse to cylinder one, then firing order.
// R9 - Output held high when crank position unknown or ignition shut down.
module csp_sync_out #(
    parameter int N = csp_pkg::MAX_PULSES,
    parameter int FIRST_W = csp_pkg::FIRST_CYC,
    parameter int OTHER_W = csp_pkg::OTHER_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [csp_pkg::ANG_W-1:0] crank_angle,
    input wire logic crank_tick,
    input wire logic crank_valid,
    input wire logic ign_shutdown,
    input wire logic [csp_pkg::ANG_W-1:0] ign_angle_base,
    input wire logic [csp_pkg::ANG_W-1:0] lead_time_tenths,
    output logic crank_sync_pulse_output
);
    import csp_pkg::*;

    typedef enum logic [1:0] {CSP_IDLE, CSP_LOW} csp_state_t;
    typedef struct packed {
        csp_state_t st;
        logic [WIDTH_W-1:0] cnt;
        logic out;
    } csp_st_t;

    csp_st_t s_r, s_nxt;
    logic [N*ANG_W-1:0] slot_angle;
    logic [N-1:0] slot_en;
    logic [N-1:0] hit;
    logic any_hit;
    logic [IDX_W-1:0] hit_idx;
    logic [WIDTH_W-1:0] hit_width;
    logic run_ok;
    logic start_ok;

    // Fall angles: rise angle minus lead; lead_time_tenths gives the angle
    // the crank sweeps in one pulse width, supplied by the angle tracker
    // at current speed. Slot 0 doubles the lead as its width doubles.
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cfg
            localparam logic [ANG_W-1:0] IG =
                ANG_W'(g * int'(DEF_SPACING));
            logic [ANG_W:0] rise;
            logic [ANG_W:0] fall;
            logic [ANG_W-1:0] lead;
            always_comb begin
                lead = (g == 0) ? ANG_W'({lead_time_tenths, 1'b0})
                                : lead_time_tenths;
                // Wrap base plus spacing first so a large base cannot
                // overflow the sum before the lead is taken off
                rise = {1'b0, ign_angle_base} + {1'b0, IG};
                if (rise >= {1'b0, CYCLE_TENTHS}) begin
                    rise = rise - {1'b0, CYCLE_TENTHS};
                end
                // Rise two degrees before ignition, itself ahead of top
                // dead centre, so the receiver has the edge in time
                rise = rise + {1'b0, CYCLE_TENTHS}
                     - {1'b0, LEAD_TENTHS}; // R3 R6
                if (rise >= {1'b0, CYCLE_TENTHS}) begin
                    rise = rise - {1'b0, CYCLE_TENTHS};
                end
                fall = rise + {1'b0, CYCLE_TENTHS} - {1'b0, lead}; // R4
                if (fall >= {1'b0, CYCLE_TENTHS}) begin
                    fall = fall - {1'b0, CYCLE_TENTHS};
                end
            end
            assign slot_angle[g*ANG_W +: ANG_W] = fall[ANG_W-1:0];
            assign slot_en[g] = (g < DEF_PULSES); // R2
        end
    endgenerate

    csp_angle_match #(.N(N)) u_match (
        .angle(crank_angle),
        .slot_angle(slot_angle),
        .slot_en(slot_en),
        .hit(hit)
    );

    // Lowest hit slot wins if two fall angles coincide
    always_comb begin
        any_hit = 1'b0;
        hit_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (hit[i]) begin
                any_hit = 1'b1;
                hit_idx = IDX_W'(i);
            end
        end
        hit_width = (hit_idx == '0) ? WIDTH_W'(FIRST_W)
                                    : WIDTH_W'(OTHER_W); // R5
    end

    // Run gate, and the strobe that starts a low phase
    assign run_ok = crank_valid && !ign_shutdown;
    assign start_ok = run_ok && crank_tick && any_hit;

    // Low phase is timed in clocks so the width is exact; the rise angle
    // then follows from the lead figure the tracker provides
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            CSP_IDLE: begin
                s_nxt.out = 1'b1; // R1
                if (start_ok) begin
                    s_nxt.st = CSP_LOW;
                    s_nxt.cnt = hit_width - 16'h0001;
                    s_nxt.out = 1'b0; // R4
                end
            end
            CSP_LOW: begin
                if (s_r.cnt == '0) begin
                    s_nxt.st = CSP_IDLE;
                    s_nxt.out = 1'b1; // R1
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            default: begin
                s_nxt.st = CSP_IDLE;
                s_nxt.out = 1'b1;
            end
        endcase
        // Abort a pulse in flight: a short low is safer than a wrong edge
        if (!run_ok) begin
            s_nxt.st = CSP_IDLE;
            s_nxt.cnt = '0;
            s_nxt.out = 1'b1; // R9
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: CSP_IDLE, cnt: '0, out: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign crank_sync_pulse_output = s_r.out;

    // Checks
    sequence s_fall;
        $fell(crank_sync_pulse_output);
    endsequence

    sequence s_start;
        (s_r.st == CSP_IDLE) && (s_nxt.st == CSP_LOW);
    endsequence

    property p_idle_high;
        @(posedge clk) disable iff (!rst_n)
        !run_ok |=> crank_sync_pulse_output;
    endproperty
    a_idle_high: assert property (p_idle_high) // R9
        else $error("sync output low while not running");

    property p_first_width;
        @(posedge clk) disable iff (!rst_n)
        s_start ##0 (hit_idx == '0)
        |=> !crank_sync_pulse_output ##0 (s_r.cnt == 16'(FIRST_W - 1));
    endproperty
    a_first_width: assert property (p_first_width) // R5
        else $error("first pulse width loaded wrong");

    property p_other_width;
        @(posedge clk) disable iff (!rst_n)
        s_start ##0 (hit_idx != '0)
        |=> (s_r.cnt == 16'(OTHER_W - 1));
    endproperty
    a_other_width: assert property (p_other_width) // R5
        else $error("other pulse width loaded wrong");

    property p_low_holds;
        @(posedge clk) disable iff (!rst_n)
        (s_r.st == CSP_LOW && s_r.cnt != '0 && run_ok)
        |=> !crank_sync_pulse_output;
    endproperty
    a_low_holds: assert property (p_low_holds) // R4
        else $error("pulse ended early");

    property p_rise_end;
        @(posedge clk) disable iff (!rst_n)
        (s_r.st == CSP_LOW && s_r.cnt == '0) |=> crank_sync_pulse_output;
    endproperty
    a_rise_end: assert property (p_rise_end) // R1
        else $error("no rise at end of pulse");

    property p_fall_cause;
        @(posedge clk) disable iff (!rst_n)
        s_fall |-> $past(start_ok);
    endproperty
    a_fall_cause: assert property (p_fall_cause) // R2
        else $error("fall without angle match");

    property p_state_out;
        @(posedge clk) disable iff (!rst_n)
        (s_r.st == CSP_IDLE) |-> crank_sync_pulse_output;
    endproperty
    a_state_out: assert property (p_state_out) // R1
        else $error("output low in idle");

    // Slot 1 rise rebuilt from the match angle plus lead and held against
    // the fixed spacing and two-degree lead, so a wrong fall sum shows
    logic [ANG_W:0] exp_rise1;
    logic [ANG_W:0] seen_rise1;
    always_comb begin
        exp_rise1 = {1'b0, ign_angle_base} + {1'b0, DEF_SPACING}
                  - {1'b0, LEAD_TENTHS};
        if (exp_rise1 >= {1'b0, CYCLE_TENTHS}) begin
            exp_rise1 = exp_rise1 - {1'b0, CYCLE_TENTHS};
        end
        seen_rise1 = {1'b0, crank_angle} + {1'b0, lead_time_tenths};
        if (seen_rise1 >= {1'b0, CYCLE_TENTHS}) begin
            seen_rise1 = seen_rise1 - {1'b0, CYCLE_TENTHS};
        end
    end

    property p_lead;
        @(posedge clk) disable iff (!rst_n)
        hit[1] |-> (seen_rise1 == exp_rise1);
    endproperty
    a_lead: assert property (p_lead) // R3
        else $error("slot hit at wrong angle");

    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        (s_r.st == CSP_LOW && !run_ok) |=> (s_r.st == CSP_IDLE);
    endproperty
    a_abort: assert property (p_abort) // R9
        else $error("pulse not aborted");
endmodule
